// File: core/fptab_pkg.sv
// fptab package: parameter table contents, register map, timing, types
package fptab_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_READ_CMD = 8'h08;
    localparam logic [7:0] ADDR_READ_DATA = 8'h0c;
    // control fields
    localparam int CTRL_WR_LATCH_BIT = 0;
    localparam int CTRL_DPD_BIT = 1;
    // status fields
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_WR_LATCH_BIT = 1;
    localparam int STAT_DPD_BIT = 2;
    localparam int STAT_ERR_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    // read command fields
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_MODE_LSB = 8;
    localparam int CMD_DUMMY_LSB = 12;
    localparam int CMD_MBITS_LSB = 16;
    // read data fields
    localparam int RDAT_VALID_BIT = 8;
    // reset values
    localparam logic CTRL_WR_LATCH_RST = 1'b0;
    localparam logic CTRL_DPD_RST = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PU_DELAY_NS = 1000;
    localparam int PU_DELAY_CYC = (PU_DELAY_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    ////////////////////////////////////////////////////////////////////////
    // table contents
    localparam logic [7:0] BLANK = 8'hff;
    localparam logic [15:0] VMAX_CODE = 16'h3600;
    localparam logic [15:0] VMIN_CODE = 16'h2700;
    localparam logic [7:0] ERASE1_EXP = 8'h0c;
    localparam logic [7:0] ERASE1_OP = 8'h20;
    localparam logic [7:0] ERASE2_EXP = 8'h10;
    localparam logic [7:0] ERASE2_OP = 8'hd8;
    localparam logic [7:0] SW_RESET_OP = 8'hff;
    localparam logic [7:0] RESET_ENABLE_OP = 8'h66;
    localparam logic [7:0] WRAP_OP = 8'hff;
    localparam logic [7:0] WRAP_LEN = 8'hff;
    localparam logic [7:0] LOCK_OP = 8'hff;
    // feature word, bit 15 down to bit 0
    localparam logic [15:0] FEATURE_WORD = {1'b0, 1'b1, 1'b0, 1'b0,
        SW_RESET_OP, 1'b0, 1'b1, 1'b1, 1'b0};
    // lock word, bit 15 down to bit 0
    localparam logic [15:0] LOCK_WORD = {2'h3, 1'b0, 1'b0, 1'b0, 1'b1,
        LOCK_OP, 1'b1, 1'b0};
    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        FPTAB_MODE_111,
        FPTAB_MODE_222,
        FPTAB_MODE_444,
        FPTAB_MODE_MIXED
    } fptab_mode_t;

    typedef struct packed {
        logic [3:0] mode_bits;
        logic [3:0] dummy;
        fptab_mode_t mode;
        logic [7:0] addr;
    } fptab_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fptab_rdat_t;
endpackage

// File: core/fptab_rom.sv
// fptab_rom: fixed parameter table lookup, byte wide
`timescale 1ns/1ps
`default_nettype none
module fptab_rom (
    input wire logic [7:0] addr,
    output logic [7:0] data
);
    // constants only, nothing writes here
    function automatic logic [7:0] lookup(input logic [7:0] a);
        unique case (a)
            8'h4c: lookup = fptab_pkg::ERASE1_EXP;
            8'h4d: lookup = fptab_pkg::ERASE1_OP;
            8'h4e: lookup = fptab_pkg::ERASE2_EXP;
            8'h4f: lookup = fptab_pkg::ERASE2_OP;
            8'h60: lookup = fptab_pkg::VMAX_CODE[7:0];
            8'h61: lookup = fptab_pkg::VMAX_CODE[15:8];
            8'h62: lookup = fptab_pkg::VMIN_CODE[7:0];
            8'h63: lookup = fptab_pkg::VMIN_CODE[15:8];
            // feature word, reset opcode inside
            8'h64: lookup = fptab_pkg::FEATURE_WORD[7:0];
            8'h65: lookup = fptab_pkg::FEATURE_WORD[15:8];
            8'h66: lookup = fptab_pkg::WRAP_OP;
            8'h67: lookup = fptab_pkg::WRAP_LEN;
            8'h68: lookup = fptab_pkg::LOCK_WORD[7:0];
            8'h69: lookup = fptab_pkg::LOCK_WORD[15:8];
            default: lookup = fptab_pkg::BLANK;
        endcase
    endfunction

    always_comb begin
        data = lookup(addr);
    end
endmodule // fptab_rom
`default_nettype wire

// File: core/fptab_top.sv
// fptab_top: parameter table read engine and power-on state, apb slave
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fptab_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    ////////////////////////////////////////////////////////////////////////
    // read sequencer states
    typedef enum logic [1:0] {
        FPTAB_IDLE,
        FPTAB_MODEBITS,
        FPTAB_DUMMY,
        FPTAB_FETCH
    } fptab_state_t;

    localparam int PU_CNT_W = $clog2(fptab_pkg::PU_DELAY_CYC + 1);
    localparam logic [PU_CNT_W-1:0] PU_LAST =
        PU_CNT_W'(fptab_pkg::PU_DELAY_CYC);

    function automatic logic mode_ok(input fptab_pkg::fptab_mode_t m);
        mode_ok = (m != fptab_pkg::FPTAB_MODE_MIXED);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus handshake decode
    logic acc;
    logic wr_hit;
    logic rd_hit;
    logic mapped;
    always_comb begin
        acc = psel & penable & ~pready;
        wr_hit = acc & pwrite;
        rd_hit = acc & ~pwrite;
        mapped = (paddr == fptab_pkg::ADDR_CTRL) ||
                 (paddr == fptab_pkg::ADDR_STATUS) ||
                 (paddr == fptab_pkg::ADDR_READ_CMD) ||
                 (paddr == fptab_pkg::ADDR_READ_DATA);
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [PU_CNT_W-1:0] pu_cnt_q, pu_cnt_d;
    logic ready_q, ready_d;
    logic write_enable_latch_q, write_enable_latch_d;
    logic dpd_q, dpd_d;
    logic err_q, err_d;
    fptab_state_t st_q, st_d;
    fptab_pkg::fptab_cmd_t cmd_q, cmd_d;
    logic [3:0] cnt_q, cnt_d;
    fptab_pkg::fptab_rdat_t rdat_q, rdat_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [7:0] rom_data;

    fptab_rom u_rom (
        .addr(cmd_q.addr),
        .data(rom_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // power-on delay and device state
    always_comb begin
        pu_cnt_d = pu_cnt_q;
        ready_d = ready_q;
        write_enable_latch_d = write_enable_latch_q;
        dpd_d = dpd_q;
        // read commands and ctrl writes are refused until the delay runs out
        if (!ready_q) begin
            if (pu_cnt_q == PU_LAST) begin
                ready_d = 1'b1;
            end else begin
                pu_cnt_d = pu_cnt_q + PU_CNT_W'(1);
            end
        end
        // ctrl writes steer latch and power-down, never the table
        if (wr_hit && paddr == fptab_pkg::ADDR_CTRL && ready_q) begin
            write_enable_latch_d = pwdata[fptab_pkg::CTRL_WR_LATCH_BIT];
            dpd_d = pwdata[fptab_pkg::CTRL_DPD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read command sequencer
    logic cmd_wr;
    logic cmd_bad;
    fptab_pkg::fptab_cmd_t cmd_in;
    always_comb begin
        // fields picked one by one, the struct is narrower than the word
        cmd_in.addr = pwdata[fptab_pkg::CMD_ADDR_LSB +: 8];
        cmd_in.mode = fptab_pkg::fptab_mode_t'(
            pwdata[fptab_pkg::CMD_MODE_LSB +: 2]);
        cmd_in.dummy = pwdata[fptab_pkg::CMD_DUMMY_LSB +: 4];
        cmd_in.mode_bits = pwdata[fptab_pkg::CMD_MBITS_LSB +: 4];
        cmd_wr = wr_hit && paddr == fptab_pkg::ADDR_READ_CMD;
        // mixed widths, asleep, not ready or busy: refused
        cmd_bad = !mode_ok(cmd_in.mode) || dpd_q || !ready_q ||
                  st_q != FPTAB_IDLE;
        st_d = st_q;
        cmd_d = cmd_q;
        cnt_d = cnt_q;
        rdat_d = rdat_q;
        err_d = err_q;
        if (wr_hit && paddr == fptab_pkg::ADDR_STATUS &&
            pwdata[fptab_pkg::STAT_ERR_BIT]) begin
            err_d = 1'b0;
        end
        unique case (st_q)
            FPTAB_IDLE: begin
                if (cmd_wr && !cmd_bad) begin
                    cmd_d = cmd_in;
                    rdat_d.valid = 1'b0;
                    // mode bits come first, host-driven
                    if (cmd_in.mode_bits != 4'h0) begin
                        cnt_d = cmd_in.mode_bits;
                        st_d = FPTAB_MODEBITS;
                    end else if (cmd_in.dummy != 4'h0) begin
                        cnt_d = cmd_in.dummy;
                        st_d = FPTAB_DUMMY;
                    end else begin
                        st_d = FPTAB_FETCH;
                    end
                end
            end
            FPTAB_MODEBITS: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    if (cmd_q.dummy != 4'h0) begin
                        cnt_d = cmd_q.dummy;
                        st_d = FPTAB_DUMMY;
                    end else begin
                        st_d = FPTAB_FETCH;
                    end
                end
            end
            FPTAB_DUMMY: begin
                // data held back until every dummy clock passed
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    st_d = FPTAB_FETCH;
                end
            end
            FPTAB_FETCH: begin
                rdat_d.data = rom_data;
                rdat_d.valid = 1'b1;
                st_d = FPTAB_IDLE;
            end
        endcase
        // set wins over a clear in the same cycle
        if (cmd_wr && cmd_bad) begin
            err_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait cycle, registered outputs
    always_comb begin
        pready_d = acc;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (acc) begin
            prdata_d = 32'h0000_0000;
            pslverr_d = !mapped;
        end
        if (rd_hit) begin
            unique case (paddr)
                fptab_pkg::ADDR_CTRL: begin
                    prdata_d[fptab_pkg::CTRL_WR_LATCH_BIT] =
                        write_enable_latch_q;
                    prdata_d[fptab_pkg::CTRL_DPD_BIT] = dpd_q;
                end
                fptab_pkg::ADDR_STATUS: begin
                    prdata_d[fptab_pkg::STAT_READY_BIT] = ready_q;
                    prdata_d[fptab_pkg::STAT_WR_LATCH_BIT] =
                        write_enable_latch_q;
                    prdata_d[fptab_pkg::STAT_DPD_BIT] = dpd_q;
                    prdata_d[fptab_pkg::STAT_ERR_BIT] = err_q;
                    prdata_d[fptab_pkg::STAT_BUSY_BIT] = st_q != FPTAB_IDLE;
                end
                fptab_pkg::ADDR_READ_CMD: begin
                    prdata_d[fptab_pkg::CMD_ADDR_LSB +: 8] = cmd_q.addr;
                    prdata_d[fptab_pkg::CMD_MODE_LSB +: 2] = cmd_q.mode;
                    prdata_d[fptab_pkg::CMD_DUMMY_LSB +: 4] = cmd_q.dummy;
                    prdata_d[fptab_pkg::CMD_MBITS_LSB +: 4] =
                        cmd_q.mode_bits;
                end
                fptab_pkg::ADDR_READ_DATA: begin
                    prdata_d[8:0] = rdat_q;
                end
                default: begin
                    prdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; ce low freezes everything
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pu_cnt_q <= '0;
            ready_q <= 1'b0;
            write_enable_latch_q <= fptab_pkg::CTRL_WR_LATCH_RST;
            dpd_q <= fptab_pkg::CTRL_DPD_RST;
            err_q <= 1'b0;
            st_q <= FPTAB_IDLE;
            cmd_q <= '0;
            cnt_q <= 4'h0;
            rdat_q <= '0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pu_cnt_q <= pu_cnt_d;
            ready_q <= ready_d;
            write_enable_latch_q <= write_enable_latch_d;
            dpd_q <= dpd_d;
            err_q <= err_d;
            st_q <= st_d;
            cmd_q <= cmd_d;
            cnt_q <= cnt_d;
            rdat_q <= rdat_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_comb begin
        prdata = prdata_q;
        pready = pready_q;
        pslverr = pslverr_q;
    end
endmodule // fptab_top
`default_nettype wire

// File: verification/fptab_properties.sv
// fptab_properties: bus and power-up checks on the fptab_top ports
`timescale 1ns/1ps
`default_nettype none
module fptab_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    ////////////////////////////////////////////////////////////////////////
    // ce-enabled cycles since reset release, saturating so it never wraps to early
    logic [7:0] up_q;
    logic [7:0] up_d;
    always_comb begin
        up_d = up_q;
        if (ce && up_q != 8'hff) begin
            up_d = up_q + 8'h01;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_q <= 8'h00;
        end else begin
            up_q <= up_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wait;
        psel && penable && !pready && ce;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    sequence s_stat;
        s_done ##0 (!pwrite && paddr == fptab_pkg::ADDR_STATUS);
    endsequence
    chk_one_wait: assert property (s_wait |=> pready)
        else $error("access phase not ended after one wait");
    chk_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("pready without an access");
    chk_err_unmapped: assert property (s_done ##0 (paddr > 8'h0c) |-> pslverr)
        else $error("unmapped access not flagged");
    chk_mapped_ok: assert property (
        s_done ##0 (paddr <= 8'h0c && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("mapped access flagged");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    chk_early_idle: assert property (
        s_stat ##0 (up_q < 8'd120) |-> prdata[2:0] == 3'h0)
        else $error("not idle standby before power-up delay");
    chk_late_ready: assert property (
        s_stat ##0 (up_q > 8'd130) |-> prdata[0])
        else $error("ready missing after power-up delay");
endmodule // fptab_properties
bind fptab_top fptab_properties u_props (.clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: verification/fptab_host.sv
// fptab_host: apb master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module fptab_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // called just after a rising edge; waits as long as the slave wants
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~d;
        // one idle edge, so a following call never drives a line twice
        @(posedge clk);
    endtask
endmodule // fptab_host
`default_nettype wire

// File: verification/testbench.sv
// testbench: self-checking bench for fptab_top over apb
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [31:0] e;
        logic [31:0] m;
        logic er;
    } fptab_note_t;
    localparam logic [7:0] ST = fptab_pkg::ADDR_STATUS;
    localparam logic [7:0] CT = fptab_pkg::ADDR_CTRL;
    localparam logic [7:0] CM = fptab_pkg::ADDR_READ_CMD;
    localparam logic [7:0] DT = fptab_pkg::ADDR_READ_DATA;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int errors, comparisons, cyc;
    fptab_note_t nq[$];
    fptab_note_t n;
    fptab_top u_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fptab_host u_host (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // note the expected answer, then run the bus cycle
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] e,
            input logic [31:0] m, input logic er);
        nq.push_back('{e, m, er});
        u_host.xfer(w, a, d, r);
    endtask
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        case (a)
            8'h4c: return 8'h0c;
            8'h4d: return 8'h20;
            8'h4e: return 8'h10;
            8'h4f: return 8'hd8;
            8'h60, 8'h62: return 8'h00;
            8'h61: return 8'h36;
            8'h63: return 8'h27;
            8'h64: return 8'hf6;
            8'h65: return 8'h4f;
            8'h68: return 8'hfe;
            8'h69: return 8'hc7;
            default: return 8'hff;
        endcase
    endfunction
    // random dummy and mode-bit counts; data must not beat them
    task automatic rd_byte(input logic [7:0] a, input logic [1:0] md);
        logic [3:0] dm, mb;
        int k;
        dm = 4'h4 + 4'($urandom % 12);
        mb = 4'($urandom % 16);
        acc(1'b1, CM, {12'h0, mb, dm, 2'h0, md, a}, 0, 0, 1'b0);
        acc(1'b0, DT, 0, 32'h0, 32'h100, 1'b0);
        k = 0;
        do begin
            acc(1'b0, DT, 0, 0, 0, 1'b0);
            k++;
        end while (r[8] !== 1'b1 && k < 60);
        acc(1'b0, DT, 0, {23'h0, 1'b1, exp_byte(a)}, 32'h1ff,
            1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            n = nq.pop_front();
            check({31'h0, pslverr}, {31'h0, n.er});
            check(prdata & n.m, n.e & n.m);
        end
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        errors = 0;
        comparisons = 0;
        cyc = 0;
        void'($urandom(32'ha0cd));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(1'b0, ST, 0, 32'h0, 32'h1f, 1'b0);
        acc(1'b1, CM, 32'h60, 0, 0, 1'b0);
        acc(1'b0, ST, 0, 32'h8, 32'h1f, 1'b0);
        repeat (130) @(posedge clk);
        acc(1'b1, ST, 32'h8, 0, 0, 1'b0);
        acc(1'b0, ST, 0, 32'h1, 32'h1f, 1'b0);
        $display("test power-up done");
        for (int i = 0; i < 20; i++) begin
            rd_byte(i < 4 ? 8'h4c + 8'(i) : 8'h5c + 8'(i),
                2'(i % 3));
        end
        $display("test table done");
        acc(1'b1, CM, 32'h360, 0, 0, 1'b0);
        acc(1'b0, ST, 0, 32'h9, 32'h1f, 1'b0);
        acc(1'b1, ST, 32'h8, 0, 0, 1'b0);
        acc(1'b1, CT, 32'h1, 0, 0, 1'b0);
        acc(1'b1, DT, 32'h0, 0, 0, 1'b0);
        acc(1'b0, ST, 0, 32'h3, 32'h1f, 1'b0);
        acc(1'b1, CT, 32'h2, 0, 0, 1'b0);
        acc(1'b1, CM, 32'h61, 0, 0, 1'b0);
        acc(1'b0, ST, 0, 32'hd, 32'h1f, 1'b0);
        acc(1'b1, CT, 32'h0, 0, 0, 1'b0);
        acc(1'b1, ST, 32'h8, 0, 0, 1'b0);
        rd_byte(8'h61, 2'h0);
        acc(1'b0, 8'h10, 0, 32'h0, 32'hffffffff, 1'b1);
        $display("test control and errors done");
        // ce low must hold a read half-way: 16 busy edges, ce low for 30
        acc(1'b1, CM, 32'h0000_f061, 0, 0, 1'b0);
        ce <= 1'b0;
        repeat (30) @(posedge clk);
        ce <= 1'b1;
        acc(1'b0, DT, 0, 32'h0, 32'h100, 1'b0);
        repeat (20) @(posedge clk);
        acc(1'b0, DT, 0, 32'h136, 32'h1ff, 1'b0);
        $display("test clock enable done");
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule // testbench
`default_nettype wire
